// >>> hw/tsp_slave_port.sv
// two-wire / smbus slave port of a temperature sensor with selector, registers and alert
// assumes pads resolve sda from sda_oe; scl, sda and strap_code are asynchronous pins
//////////////////////////////////////////////////////////////////////////////
module tsp_slave_port
	import tsp_pkg::*;
#(
	parameter int unsigned TOUT_N  = TIMEOUT_CYC,
	parameter int unsigned CONV_N  = CONV_CYC,
	parameter int unsigned STBY0_N = STBY0_CYC,
	parameter int unsigned STBY1_N = STBY1_CYC,
	parameter int unsigned STBY2_N = STBY2_CYC,
	parameter int unsigned STBY3_N = STBY3_CYC
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output wire logic        sda_out,
	output wire logic        sda_oe,
	input  wire logic [1:0]  strap_code,
	input  wire logic [11:0] temp_sample,
	output wire logic        alert_pin,
	output wire logic        hs_mode,
	output wire logic        conv_busy
);
	function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic lo,
		input logic [15:0] t, input logic [15:0] c, input logic [15:0] l, input logic [15:0] h);
		logic [15:0] w;
		w = t;
		case (p)
			PTR_TEMP: w = t;
			PTR_CFG:  w = c;
			PTR_LOW:  w = l;
			default:  w = h;
		endcase
		return lo ? w[7:0] : w[15:8];
	endfunction

	tsp_conv_if cv ();

	logic        scl_m, scl_s, scl_d;
	logic        sda_m, sda_s, sda_d;
	logic [1:0]  strap_m, strap_s;
	logic        scl_rise, scl_fall, start_c, stop_c;

	tsp_st_e     st_r, st_nxt;
	tsp_role_e   role_r, role_nxt;
	logic [3:0]  bitcnt_r, bitcnt_nxt;
	logic [7:0]  sh_r, sh_nxt;
	logic        ack_r, ack_nxt;
	logic        mack_r, mack_nxt;
	logic        idx_r, idx_nxt;
	logic [7:0]  hold_r, hold_nxt;
	logic [1:0]  ptr_r, ptr_nxt;
	logic [15:0] temp_r, temp_nxt;
	logic [15:0] low_r, low_nxt;
	logic [15:0] high_r, high_nxt;
	logic [1:0]  cr_r, cr_nxt;
	logic [1:0]  mode_r, mode_nxt;
	logic [1:0]  hys_r, hys_nxt;
	logic        fh_r, fh_nxt;
	logic        fl_r, fl_nxt;
	logic        tm_r, tm_nxt;
	logic        pol_r, pol_nxt;
	logic        aint_r, aint_nxt;
	logic        cmp_r, cmp_nxt;
	logic        apin_r, apin_nxt;
	logic [1:0]  strap_r, strap_nxt;
	logic        hs_r, hs_nxt;
	logic        oe_r, oe_nxt;
	logic        busy_r, busy_nxt;
	logic [31:0] tout_r, tout_nxt;
	logic        start_r, start_nxt;
	logic        rst_r, rst_nxt;

	logic [15:0] cfg_w, wr_w;
	logic [6:0]  my_addr;
	logic        alert_act, tout_hit;
	logic [7:0]  ld_byte;
	logic signed [12:0] t13, lo13, hi13, hys13, lo_h, hi_h;

	assign sda_out   = 1'h0;
	assign sda_oe    = oe_r;
	assign alert_pin = apin_r;
	assign hs_mode   = hs_r;
	assign conv_busy = cv.busy;

	assign cv.mode    = mode_r;
	assign cv.rate    = cr_r;
	assign cv.start   = start_r;
	assign cv.restart = rst_r;

	tsp_conv #(
		.CONV_N  (CONV_N),
		.STBY0_N (STBY0_N),
		.STBY1_N (STBY1_N),
		.STBY2_N (STBY2_N),
		.STBY3_N (STBY3_N)
	) u_conv (
		.clk    (clk),
		.resetn (resetn),
		.cv     (cv.seq)
	);

	//////////////////////////////////////////////////////////////////////////////
	// pins are oversampled; the 4 ns clock leaves many samples per high-speed bit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_m   <= 1'h1;
			scl_s   <= 1'h1;
			scl_d   <= 1'h1;
			sda_m   <= 1'h1;
			sda_s   <= 1'h1;
			sda_d   <= 1'h1;
			strap_m <= 2'h0;
			strap_s <= 2'h0;
		end else begin
			scl_m   <= scl_in;
			scl_s   <= scl_m;
			scl_d   <= scl_s;
			sda_m   <= sda_in;
			sda_s   <= sda_m;
			sda_d   <= sda_s;
			strap_m <= strap_code;
			strap_s <= strap_m;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	assign cfg_w     = {1'h0, cr_r, fh_r, fl_r, tm_r, mode_r, pol_r, 1'h0, hys_r, 4'h0};
	assign wr_w      = {hold_r, sh_r};
	assign my_addr   = {ADDR_FIXED, strap_r};
	assign alert_act = tm_r ? aint_r : cmp_r;
	assign tout_hit  = (tout_r == 32'(TOUT_N - 1));
	assign ld_byte   = (role_r == RL_ARA) ? {my_addr, fh_r} :
		rd_byte(ptr_r, idx_r, temp_r, cfg_w, low_r, high_r);

	assign t13   = {temp_sample[11], temp_sample};
	assign lo13  = {low_r[15], low_r[15:4]};
	assign hi13  = {high_r[15], high_r[15:4]};
	assign hys13 = (hys_r == 2'h0) ? 13'h0000 : 13'(HYS_1C << (hys_r - 2'h1));
	assign lo_h  = lo13 + hys13;
	assign hi_h  = hi13 - hys13;

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt     = st_r;
		role_nxt   = role_r;
		bitcnt_nxt = bitcnt_r;
		sh_nxt     = sh_r;
		ack_nxt    = ack_r;
		mack_nxt   = mack_r;
		idx_nxt    = idx_r;
		hold_nxt   = hold_r;
		ptr_nxt    = ptr_r;
		temp_nxt   = temp_r;
		low_nxt    = low_r;
		high_nxt   = high_r;
		cr_nxt     = cr_r;
		mode_nxt   = mode_r;
		hys_nxt    = hys_r;
		fh_nxt     = fh_r;
		fl_nxt     = fl_r;
		tm_nxt     = tm_r;
		pol_nxt    = pol_r;
		aint_nxt   = aint_r;
		cmp_nxt    = cmp_r;
		strap_nxt  = strap_r;
		hs_nxt     = hs_r;
		oe_nxt     = oe_r;
		busy_nxt   = busy_r;
		start_nxt  = 1'h0;
		rst_nxt    = 1'h0;
		tout_nxt   = (busy_r && (!scl_s || !sda_s)) ? tout_r + 32'h1 : 32'h0;

		if (busy_r && tout_hit) begin
			st_nxt   = ST_IDLE;
			oe_nxt   = 1'h0;
			busy_nxt = 1'h0;
			tout_nxt = 32'h0;
		end else if (start_c) begin
			st_nxt     = ST_RECV;
			role_nxt   = RL_ADDR;
			bitcnt_nxt = 4'h0;
			oe_nxt     = 1'h0;
			busy_nxt   = 1'h1;
			strap_nxt  = strap_s;
		end else if (stop_c) begin
			st_nxt   = ST_IDLE;
			oe_nxt   = 1'h0;
			busy_nxt = 1'h0;
			hs_nxt   = 1'h0;
		end else begin
			case (st_r)
				ST_RECV: begin
					if (scl_rise) begin
						sh_nxt     = {sh_r[6:0], sda_s};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end else if (scl_fall && bitcnt_r == BITS_PER_BYTE) begin
						ack_nxt = 1'h1;
						st_nxt  = ST_ACK;
						case (role_r)
							RL_ADDR: begin
								idx_nxt = 1'h0;
								if (sh_r == ARA_BYTE && alert_act) begin
									role_nxt = RL_ARA;
								end else if (sh_r[7:1] == my_addr) begin
									role_nxt = sh_r[0] ? RL_RD : RL_PTR;
								end else if (sh_r == GC_ADDR) begin
									role_nxt = RL_GC;
								end else if (sh_r[7:3] == HS_CODE) begin
									ack_nxt = 1'h0;
									hs_nxt  = 1'h1;
								end else begin
									ack_nxt = 1'h0;
								end
							end
							RL_PTR: begin
								ptr_nxt  = sh_r[1:0];
								role_nxt = RL_DATA;
							end
							RL_DATA: begin
								idx_nxt = !idx_r;
								if (!idx_r) begin
									hold_nxt = sh_r;
								end else begin
									case (ptr_r)
										PTR_CFG: begin
											cr_nxt  = wr_w[CFG_CR +: 2];
											tm_nxt  = wr_w[CFG_TM];
											pol_nxt = wr_w[CFG_POL];
											hys_nxt = wr_w[CFG_HYS +: 2];
											mode_nxt = wr_w[CFG_MODE +: 2];
											start_nxt = (wr_w[CFG_MODE +: 2] == 2'h1) &&
												(mode_r == 2'h0) && !cv.busy;
										end
										PTR_LOW:  low_nxt  = wr_w;
										PTR_HIGH: high_nxt = wr_w;
										default:  low_nxt  = low_r;
									endcase
								end
							end
							RL_GC: begin
								if (sh_r == GC_STRAP) begin
									strap_nxt = strap_s;
								end else if (sh_r == GC_RESET) begin
									temp_nxt = TEMP_RST;
									low_nxt  = LOW_RST;
									high_nxt = HIGH_RST;
									ptr_nxt  = PTR_RST;
									cr_nxt   = CFG_RST[CFG_CR +: 2];
									tm_nxt   = CFG_RST[CFG_TM];
									pol_nxt  = CFG_RST[CFG_POL];
									hys_nxt  = CFG_RST[CFG_HYS +: 2];
									mode_nxt = CFG_RST[CFG_MODE +: 2];
									fh_nxt   = 1'h0;
									fl_nxt   = 1'h0;
									aint_nxt = 1'h0;
									cmp_nxt  = 1'h0;
									rst_nxt  = 1'h1;
								end else begin
									ack_nxt = 1'h0;
								end
							end
							default: ack_nxt = 1'h0;
						endcase
						oe_nxt = ack_nxt;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						oe_nxt = 1'h0;
						if (!ack_r) begin
							st_nxt = ST_IDLE;
						end else if (role_r == RL_RD || role_r == RL_ARA) begin
							st_nxt     = ST_SEND;
							sh_nxt     = ld_byte;
							oe_nxt     = !ld_byte[7];
							bitcnt_nxt = 4'h1;
							idx_nxt    = !idx_r;
							if (role_r == RL_RD && ptr_r == PTR_CFG && !idx_r) begin
								fh_nxt   = 1'h0;
								fl_nxt   = 1'h0;
								aint_nxt = 1'h0;
							end
						end else begin
							st_nxt     = ST_RECV;
							bitcnt_nxt = 4'h0;
						end
					end
				end
				ST_SEND: begin
					if (scl_rise && !oe_r && !sda_s) begin
						st_nxt = ST_IDLE;
					end else if (scl_fall) begin
						if (bitcnt_r == BITS_PER_BYTE) begin
							oe_nxt = 1'h0;
							st_nxt = ST_MACK;
						end else begin
							sh_nxt     = {sh_r[6:0], 1'h0};
							oe_nxt     = !sh_r[6];
							bitcnt_nxt = bitcnt_r + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_nxt = !sda_s;
					end else if (scl_fall) begin
						st_nxt = ST_IDLE;
						if (role_r == RL_ARA) begin
							aint_nxt = 1'h0;
						end else if (mack_r) begin
							st_nxt     = ST_SEND;
							sh_nxt     = ld_byte;
							oe_nxt     = !ld_byte[7];
							bitcnt_nxt = 4'h1;
							idx_nxt    = !idx_r;
						end
					end
				end
				default: begin
					oe_nxt = 1'h0;
				end
			endcase
		end

		if (cv.os_done && mode_nxt == 2'h1) begin
			mode_nxt = 2'h0;
		end
		// a finishing conversion sets flags after any clear in the same cycle
		if (cv.done) begin
			temp_nxt = {temp_sample, 4'h0};
			if (t13 > hi13) begin
				fh_nxt = 1'h1;
			end
			if (t13 < lo13) begin
				fl_nxt = 1'h1;
			end
			if (t13 > hi13 || t13 < lo13) begin
				cmp_nxt  = 1'h1;
				aint_nxt = aint_nxt | tm_r;
			end else if (t13 > lo_h && t13 < hi_h) begin
				cmp_nxt = 1'h0;
			end
		end
		apin_nxt = pol_nxt ? (tm_nxt ? aint_nxt : cmp_nxt) : !(tm_nxt ? aint_nxt : cmp_nxt);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r     <= ST_IDLE;
			role_r   <= RL_ADDR;
			bitcnt_r <= 4'h0;
			sh_r     <= 8'h00;
			ack_r    <= 1'h0;
			mack_r   <= 1'h0;
			idx_r    <= 1'h0;
			hold_r   <= 8'h00;
			ptr_r    <= PTR_RST;
			temp_r   <= TEMP_RST;
			low_r    <= LOW_RST;
			high_r   <= HIGH_RST;
			cr_r     <= CFG_RST[CFG_CR +: 2];
			mode_r   <= CFG_RST[CFG_MODE +: 2];
			hys_r    <= CFG_RST[CFG_HYS +: 2];
			fh_r     <= 1'h0;
			fl_r     <= 1'h0;
			tm_r     <= CFG_RST[CFG_TM];
			pol_r    <= CFG_RST[CFG_POL];
			aint_r   <= 1'h0;
			cmp_r    <= 1'h0;
			apin_r   <= 1'h1;
			strap_r  <= 2'h0;
			hs_r     <= 1'h0;
			oe_r     <= 1'h0;
			busy_r   <= 1'h0;
			tout_r   <= 32'h0;
			start_r  <= 1'h0;
			rst_r    <= 1'h0;
		end else begin
			st_r     <= st_nxt;
			role_r   <= role_nxt;
			bitcnt_r <= bitcnt_nxt;
			sh_r     <= sh_nxt;
			ack_r    <= ack_nxt;
			mack_r   <= mack_nxt;
			idx_r    <= idx_nxt;
			hold_r   <= hold_nxt;
			ptr_r    <= ptr_nxt;
			temp_r   <= temp_nxt;
			low_r    <= low_nxt;
			high_r   <= high_nxt;
			cr_r     <= cr_nxt;
			mode_r   <= mode_nxt;
			hys_r    <= hys_nxt;
			fh_r     <= fh_nxt;
			fl_r     <= fl_nxt;
			tm_r     <= tm_nxt;
			pol_r    <= pol_nxt;
			aint_r   <= aint_nxt;
			cmp_r    <= cmp_nxt;
			apin_r   <= apin_nxt;
			strap_r  <= strap_nxt;
			hs_r     <= hs_nxt;
			oe_r     <= oe_nxt;
			busy_r   <= busy_nxt;
			tout_r   <= tout_nxt;
			start_r  <= start_nxt;
			rst_r    <= rst_nxt;
		end
	end
endmodule

// >>> pkg/tsp_pkg.sv
// constants, codes and state types of the sensor two-wire slave port
// assumes a 250 MHz system clock; long counts are overridable at the top module
package tsp_pkg;
	localparam int unsigned CLK_MHZ     = 250;
	localparam int unsigned TIMEOUT_US  = 28000;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int unsigned CONV_US     = 27000;
	localparam int unsigned CONV_CYC    = CONV_US * CLK_MHZ;
	// conversion periods for rate codes 00..11: 0.25 Hz, 1 Hz, 4 Hz, 16 Hz
	localparam int unsigned PERIOD0_US  = 4000000;
	localparam int unsigned PERIOD1_US  = 1000000;
	localparam int unsigned PERIOD2_US  = 250000;
	localparam int unsigned PERIOD3_US  = 62500;
	localparam int unsigned STBY0_CYC   = (PERIOD0_US - CONV_US) * CLK_MHZ;
	localparam int unsigned STBY1_CYC   = (PERIOD1_US - CONV_US) * CLK_MHZ;
	localparam int unsigned STBY2_CYC   = (PERIOD2_US - CONV_US) * CLK_MHZ;
	localparam int unsigned STBY3_CYC   = (PERIOD3_US - CONV_US) * CLK_MHZ;

	localparam logic [1:0] PTR_TEMP = 2'h0;
	localparam logic [1:0] PTR_CFG  = 2'h1;
	localparam logic [1:0] PTR_LOW  = 2'h2;
	localparam logic [1:0] PTR_HIGH = 2'h3;

	localparam logic [7:0] ARA_BYTE   = 8'h19;
	localparam logic [7:0] GC_ADDR    = 8'h00;
	localparam logic [7:0] GC_STRAP   = 8'h04;
	localparam logic [7:0] GC_RESET   = 8'h06;
	localparam logic [4:0] HS_CODE    = 5'h01;
	localparam logic [4:0] ADDR_FIXED = 5'h12;

	localparam logic [15:0] TEMP_RST = 16'h0000;
	localparam logic [15:0] CFG_RST  = 16'h2210;
	localparam logic [15:0] LOW_RST  = 16'h8000;
	localparam logic [15:0] HIGH_RST = 16'h7FF0;
	localparam logic [1:0]  PTR_RST  = 2'h0;

	localparam int CFG_CR   = 13;
	localparam int CFG_TM   = 10;
	localparam int CFG_MODE = 8;
	localparam int CFG_POL  = 7;
	localparam int CFG_HYS  = 4;

	localparam logic [12:0] HYS_1C = 13'h0010;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_ACK  = 5'h04,
		ST_SEND = 5'h08,
		ST_MACK = 5'h10
	} tsp_st_e;

	typedef enum logic [5:0] {
		RL_ADDR = 6'h01,
		RL_PTR  = 6'h02,
		RL_DATA = 6'h04,
		RL_GC   = 6'h08,
		RL_RD   = 6'h10,
		RL_ARA  = 6'h20
	} tsp_role_e;

	typedef enum logic [2:0] {
		CV_IDLE = 3'h1,
		CV_RUN  = 3'h2,
		CV_WAIT = 3'h4
	} tsp_cv_e;
endpackage

// >>> pkg/tsp_conv_if.sv
// carrier between the serial port and its conversion sequencer
// assumes both ends run on the same clock
interface tsp_conv_if;
	logic [1:0] mode;
	logic [1:0] rate;
	logic       start;
	logic       restart;
	logic       done;
	logic       os_done;
	logic       busy;
	modport ctl (output mode, output rate, output start, output restart,
		input done, input os_done, input busy);
	modport seq (input mode, input rate, input start, input restart,
		output done, output os_done, output busy);
endinterface

// >>> hw/tsp_conv.sv
// conversion sequencer: shutdown, one-shot and continuous modes with standby delay
// assumes start and restart are one-cycle pulses on clk
module tsp_conv
	import tsp_pkg::*;
#(
	parameter int unsigned CONV_N  = CONV_CYC,
	parameter int unsigned STBY0_N = STBY0_CYC,
	parameter int unsigned STBY1_N = STBY1_CYC,
	parameter int unsigned STBY2_N = STBY2_CYC,
	parameter int unsigned STBY3_N = STBY3_CYC
) (
	input  wire logic clk,
	input  wire logic resetn,
	tsp_conv_if.seq   cv
);
	tsp_cv_e     st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic        done_r, done_nxt;
	logic        os_r, os_nxt;
	logic [31:0] stby_last;

	assign cv.done    = done_r;
	assign cv.os_done = os_r;
	assign cv.busy    = (st_r == CV_RUN);

	always_comb begin
		case (cv.rate)
			2'h0:    stby_last = 32'(STBY0_N - 1);
			2'h1:    stby_last = 32'(STBY1_N - 1);
			2'h2:    stby_last = 32'(STBY2_N - 1);
			default: stby_last = 32'(STBY3_N - 1);
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r + 32'h1;
		done_nxt = 1'h0;
		os_nxt   = 1'h0;
		case (st_r)
			CV_IDLE: begin
				cnt_nxt = 32'h0;
				if (cv.start || cv.restart || cv.mode[1]) begin
					st_nxt = CV_RUN;
				end
			end
			CV_RUN: begin
				if (cv.restart) begin
					cnt_nxt = 32'h0;
				end else if (cnt_r == 32'(CONV_N - 1)) begin
					// shutdown waits here until the running conversion ends
					done_nxt = 1'h1;
					cnt_nxt  = 32'h0;
					os_nxt   = (cv.mode == 2'h1);
					st_nxt   = cv.mode[1] ? CV_WAIT : CV_IDLE;
				end
			end
			CV_WAIT: begin
				if (cv.restart) begin
					st_nxt  = CV_RUN;
					cnt_nxt = 32'h0;
				end else if (!cv.mode[1]) begin
					st_nxt = CV_IDLE;
				end else if (cnt_r == stby_last) begin
					st_nxt  = CV_RUN;
					cnt_nxt = 32'h0;
				end
			end
			default: begin
				st_nxt = CV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r   <= CV_IDLE;
			cnt_r  <= 32'h0;
			done_r <= 1'h0;
			os_r   <= 1'h0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			done_r <= done_nxt;
			os_r   <= os_nxt;
		end
	end
endmodule

// >>> verification/tsp_slave_port_asserts.sv
// pin-level assertions for the two-wire slave port
// assumes a bind onto tsp_slave_port; bus pins are seen raw, ahead of the port's synchronisers
module tsp_slave_port_asserts #(
	parameter int unsigned TOUT_N = 400
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic alert_pin,
	input wire logic hs_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned low_cnt_r;
	int unsigned low_cnt_nxt;

	//////////////////////////////////////////////////////////////////////////////
	// saturating count of clock low time; saturation keeps it from wrapping on long clock-low stretches
	always_comb begin
		low_cnt_nxt = low_cnt_r;
		if (scl_in)
			low_cnt_nxt = 0;
		else if (low_cnt_r < TOUT_N + 64)
			low_cnt_nxt = low_cnt_r + 1;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			low_cnt_r <= 0;
		else
			low_cnt_r <= low_cnt_nxt;
	end

	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_odrain_low: assert property (sda_out == 1'b0)
		else $error("sda output level not low");
	chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda drive changed while clock high");
	chk_frame_release: assert property ((($rose(sda_in) || $fell(sda_in)) && scl_in && $past(scl_in))
		|-> ##[1:4] !sda_oe [*6]) else $error("sda held after start or stop");
	chk_hs_nack: assert property ($rose(hs_mode) |-> !sda_oe [*8])
		else $error("hs code acknowledged");
	chk_hs_stop: assert property (hs_mode && scl_in && $rose(sda_in) |-> ##[1:8] !hs_mode)
		else $error("hs mode kept after stop");
	chk_hs_hold: assert property ($fell(hs_mode) |-> scl_in && sda_in)
		else $error("hs mode left without stop");
	chk_line_tout: assert property (low_cnt_r > TOUT_N + 8 |-> !sda_oe)
		else $error("bus not released after timeout");
	chk_reset_idle: assert property ($rose(resetn) |-> alert_pin && !sda_oe && !hs_mode)
		else $error("outputs not idle after reset");

	cov_hs: cover property ($rose(hs_mode));
	cov_alert: cover property ($fell(alert_pin));
	cov_tout: cover property (low_cnt_r > TOUT_N + 8);
endmodule

bind tsp_slave_port tsp_slave_port_asserts #(.TOUT_N(TOUT_N)) u_asserts (.clk(clk), .resetn(resetn),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .alert_pin(alert_pin),
	.hs_mode(hs_mode));

// >>> verification/tsp_bus_master.sv
// bus master model: start, stop and byte transfers at an 80 ns clock period
// assumes the bench resolves the open-drain data wire with a pull-up
module tsp_bus_master (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int Q = 20;

	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	//////////////////////////////////////////////////////////////////////////////
	// also serves as repeated start: data is released first while clock is low
	task automatic start_c();
		sda_m = 1'b1;
		#Q scl = 1'b1;
		#Q sda_m = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stop_c();
		sda_m = 1'b0;
		#Q scl = 1'b1;
		#Q sda_m = 1'b1;
		#Q;
		#Q;
	endtask
	// clock never stalls inside a bit, so the port timeout stays quiet
	task automatic bit_io(input logic b, output logic rb);
		sda_m = b;
		#Q scl = 1'b1;
		#Q rb = sda_bus;
		#Q scl = 1'b0;
		#Q;
	endtask
	// m_ack high releases the ninth bit: nack on reads, listen on writes
	task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] rv, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], rv[i]);
		bit_io(m_ack, ack);
	endtask
endmodule

// >>> verification/testbench.sv
// self-checking bench for the two-wire slave port, driven through the bus master model
// assumes tsp_pkg, both design modules, the checker and the master model are compiled first
module testbench
	import tsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned TOUT_T = 400;
	localparam logic [11:0] TSAMP  = 12'h640;
	localparam logic [15:0] TEMP_V = {TSAMP, 4'h0};
	localparam logic [7:0]  WR_A   = {ADDR_FIXED, 2'h0, 1'b0};
	localparam logic [7:0]  RD_A   = WR_A | 8'h01;
	logic        clk = 1'b0;
	logic        resetn;
	wire         scl, sda_m, sda_bus, sda_out, sda_oe, alert_pin, hs_mode, conv_busy;
	int          n_errors = 0;
	int          samples_checked = 0;
	logic [15:0] v;
	logic [7:0]  r;
	logic        a;
	logic [1:0]  strap = 2'h0;
	logic [15:0] rst_tab [4] = '{TEMP_V, CFG_RST, LOW_RST, HIGH_RST};
	logic [7:0]  gc_cmd [3] = '{GC_STRAP, 8'h08, GC_RESET};
	logic [15:0] gc_high [3] = '{16'h5000, 16'h5000, HIGH_RST};

	assign sda_bus = (sda_oe ? sda_out : 1'b1) & sda_m;
	always #2 clk = ~clk;

	tsp_bus_master MST (.scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));
	tsp_slave_port #(.TOUT_N(TOUT_T), .CONV_N(100), .STBY0_N(50), .STBY1_N(2000), .STBY2_N(150),
		.STBY3_N(200)) DUT (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
		.sda_oe(sda_oe), .strap_code(strap), .temp_sample(TSAMP), .alert_pin(alert_pin), .hs_mode(hs_mode),
		.conv_busy(conv_busy));

	//////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		check16({15'h0, got}, {15'h0, exp});
	endtask
	task automatic wait_sig(input bit sel, input logic lvl);
		for (int i = 0; i < 5000; i++) begin
			@(negedge clk);
			if ((sel ? conv_busy : alert_pin) === lvl)
				return;
		end
		n_errors++;
		$display("CHECK FAILED at %0t: wait gave up, got %h exp %h", $time, sel ? conv_busy : alert_pin, lvl);
		finish_test();
	endtask
	task automatic wr(input logic [1:0] sel, input logic [15:0] d, input bit two);
		MST.start_c();
		MST.xfer(WR_A, 1'b1, r, a);
		check1(a, 1'b0);
		MST.xfer({6'h00, sel}, 1'b1, r, a);
		check1(a, 1'b0);
		if (two) begin
			MST.xfer(d[15:8], 1'b1, r, a);
			check1(a, 1'b0);
			MST.xfer(d[7:0], 1'b1, r, a);
			check1(a, 1'b0);
		end
		MST.stop_c();
	endtask
	task automatic rd(input logic [1:0] sel, input bit setp, output logic [15:0] d);
		if (setp) begin
			MST.start_c();
			MST.xfer(WR_A, 1'b1, r, a);
			MST.xfer({6'h00, sel}, 1'b1, r, a);
		end
		MST.start_c();
		MST.xfer(RD_A, 1'b1, r, a);
		check1(a, 1'b0);
		MST.xfer(8'hFF, 1'b0, d[15:8], a);
		MST.xfer(8'hFF, 1'b1, d[7:0], a);
		MST.stop_c();
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		wait_sig(1'b1, 1'b0);
		rd(PTR_TEMP, 1'b0, v);
		check16(v, TEMP_V);
		for (int p = 0; p < 4; p++) begin
			rd(p[1:0], 1'b1, v);
			check16(v, rst_tab[p]);
		end
		rd(PTR_TEMP, 1'b0, v);
		check16(v, HIGH_RST);
		$display("test reset values done");

		wr(PTR_TEMP, 16'h1234, 1'b1);
		wr(PTR_LOW, 16'hC900, 1'b1);
		wr(PTR_HIGH, 16'h5000, 1'b1);
		rd(PTR_TEMP, 1'b1, v);
		check16(v, TEMP_V);
		rd(PTR_LOW, 1'b1, v);
		check16(v, 16'hC900);
		rd(PTR_HIGH, 1'b1, v);
		check16(v, 16'h5000);
		$display("test register writes done");

		// interrupt mode; the over-limit crossing latches the alert
		wr(PTR_CFG, CFG_RST | 16'h0400, 1'b1);
		wait_sig(1'b0, 1'b0);
		MST.start_c();
		MST.xfer(ARA_BYTE, 1'b1, r, a);
		check1(a, 1'b0);
		MST.xfer(8'hFF, 1'b1, r, a);
		MST.stop_c();
		check16({8'h00, r}, {8'h00, RD_A});
		check1(alert_pin, 1'b1);
		rd(PTR_CFG, 1'b1, v);
		check16(v, CFG_RST | 16'h1400);
		MST.start_c();
		MST.xfer(ARA_BYTE, 1'b1, r, a);
		MST.stop_c();
		check1(a, 1'b1);
		check1(alert_pin, 1'b1);
		$display("test alert response done");

		for (int k = 0; k < 3; k++) begin
			MST.start_c();
			MST.xfer(GC_ADDR, 1'b1, r, a);
			check1(a, 1'b0);
			MST.xfer(gc_cmd[k], 1'b1, r, a);
			MST.stop_c();
			check1(a, k == 1);
			rd(PTR_HIGH, 1'b1, v);
			check16(v, gc_high[k]);
		end
		rd(PTR_CFG, 1'b1, v);
		check16(v, CFG_RST);
		// strap is latched at each start, so the old address must now be refused
		strap = 2'h1;
		MST.start_c();
		MST.xfer(WR_A, 1'b1, r, a);
		MST.stop_c();
		check1(a, 1'b1);
		MST.start_c();
		MST.xfer(WR_A | 8'h02, 1'b1, r, a);
		MST.stop_c();
		check1(a, 1'b0);
		strap = 2'h0;
		$display("test general call done");

		MST.start_c();
		MST.xfer({HS_CODE, 3'h5}, 1'b1, r, a);
		check1(a, 1'b1);
		check1(hs_mode, 1'b1);
		MST.start_c();
		MST.xfer(WR_A, 1'b1, r, a);
		MST.xfer({6'h00, PTR_LOW}, 1'b1, r, a);
		check1(hs_mode, 1'b1);
		MST.stop_c();
		check1(hs_mode, 1'b0);
		rd(PTR_LOW, 1'b0, v);
		check16(v, LOW_RST);
		$display("test high speed done");

		// clock parked low while the port drives a data bit
		rd(PTR_TEMP, 1'b1, v);
		MST.start_c();
		MST.xfer(RD_A, 1'b1, r, a);
		check1(sda_oe, !TEMP_V[15]);
		repeat (TOUT_T + 40) @(negedge clk);
		check1(sda_oe, 1'b0);
		MST.stop_c();
		rd(PTR_TEMP, 1'b0, v);
		check16(v, TEMP_V);
		$display("test timeout done");

		wr(PTR_CFG, CFG_RST & 16'hFCFF, 1'b1);
		wait_sig(1'b1, 1'b0);
		repeat (600) @(negedge clk);
		check1(conv_busy, 1'b0);
		wr(PTR_CFG, (CFG_RST & 16'hFCFF) | 16'h0100, 1'b1);
		wait_sig(1'b1, 1'b1);
		wait_sig(1'b1, 1'b0);
		rd(PTR_CFG, 1'b1, v);
		check16(v, CFG_RST & 16'hFCFF);
		$display("test conversion modes done");
		finish_test();
	end
endmodule
